// >>> core/mrg_cfg.svh
// Timing and layout constants for the reset generator.
// Assumes clk is the oscillator clock at 200 MHz.
`ifndef MRG_CFG_SVH
`define MRG_CFG_SVH
`define MRG_CLK_NS        5
`define MRG_OSC_PER_MC    4
`define MRG_EXT_MIN_MC    3
`define MRG_EXT_MIN_CYC   (`MRG_EXT_MIN_MC * `MRG_OSC_PER_MC)
`define MRG_INT_MIN_CYC   8
`define MRG_INT_MAX_CYC   24
`define MRG_INT_HOLD_CYC  16
`define MRG_CNT_W         5
`define MRG_PC_W          20
`define MRG_VEC_ADDR      20'hffffc
`define MRG_VEC_LAST      20'hffffe
`define MRG_PS_W          16
`define MRG_IRQ_W         16
`define MRG_CLK_SEL_HI    7
`define MRG_CLK_SEL_LO    5
`define MRG_CLK_DEAD      3'h0
`define MRG_RAM_LO        20'h00040
`define MRG_RAM_HI        20'h0083f
`define MRG_SFR_LO        20'h00000
`define MRG_SFR_HI        20'h0003f
`define MRG_DBR_LO        20'h00f80
`define MRG_DBR_HI        20'h00fff
`endif

// >>> core/mrg_pkg.sv
// Types shared by the reset generator files.
// Assumes the constants header is available on the include path.
`include "mrg_cfg.svh"
package mrg_pkg;
  typedef logic [`MRG_PC_W-1:0] mrg_addr_t;
  typedef struct packed {
    logic [1:0]            bank_selector;
    logic                  jump_status_flag;
    logic                  irq_master_enable;
    logic [`MRG_IRQ_W-1:0] irq_individual_enables;
    logic [`MRG_IRQ_W-1:0] irq_latches;
    logic [`MRG_PS_W-1:0]  prescaler;
    logic                  watchdog_enable;
  } mrg_core_init_s;
  typedef struct packed {
    logic ext;
    logic trap;
    logic wdt;
    logic sysclk;
  } mrg_cause_s;
endpackage

// >>> core/mrg_pulse.sv
// Stretches an internal reset request to a pulse of at least HOLD cycles.
// Assumes a single clock; trig is a synchronous level or pulse.
`timescale 1ns/1ps
`include "mrg_cfg.svh"
module mrg_pulse #(
  parameter int HOLD = `MRG_INT_HOLD_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trig,
  output logic      active
);
  logic [`MRG_CNT_W-1:0] cnt;

  // A held request keeps retriggering, so the pulse persists while it stands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (trig) begin
      cnt <= `MRG_CNT_W'(HOLD);
    end else if (cnt != '0) begin
      cnt <= cnt - `MRG_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
    end else begin
      active <= trig || (cnt > `MRG_CNT_W'(1));
    end
  end
endmodule

// >>> core/mrg_reset_gen.sv
// Reset generator: merges pin, address-trap, watchdog and clock-stop resets.
// Assumes clk is the oscillator clock and all inputs are synchronous to it.
// Reset pin is open-drain: only low is driven, the board pulls it high.
// Summary of operation
// - Any of four causes enters reset
// - Pin may pull low briefly at power-up
// - Reset clears bank selector, sets jump flag
// - Reset clears interrupt enables and latches
// - Reset clears prescaler, keeps watchdog enabled
// - Pin low three machine cycles applies reset
// - Release fetches start from reset vector
// - Fetch from RAM, debug, SPECIAL_FUNCTION_AREA traps
// - Trap reset drives pin low
// - Internal resets last 8 to 24 cycles; a held watchdog or clock-stop request keeps the pin driven longer
// - Clock select bits all zero force reset
// - Clock-stop reset drives pin low
`timescale 1ns/1ps
`include "mrg_cfg.svh"
module mrg_reset_gen (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    reset_pin_in_n,
  output logic                         reset_pin_out_n,
  output logic                         reset_pin_oe_n,
  input  wire logic                    fetch_valid,
  input  wire mrg_pkg::mrg_addr_t      fetch_addr,
  input  wire logic                    wdt_reset_req,
  input  wire logic [7:0]              sys_ctrl_two,
  output logic                         core_reset,
  output mrg_pkg::mrg_core_init_s      core_init,
  output mrg_pkg::mrg_addr_t           vector_addr,
  output logic                         vector_fetch,
  output mrg_pkg::mrg_cause_s          reset_cause
);
  import mrg_pkg::*;

  logic [`MRG_CNT_W-1:0] ext_cnt;
  logic                  ext_clear;
  logic                  ext_reset;
  logic                  in_sfr;
  logic                  in_ram;
  logic                  in_dbr;
  logic                  trap_hit;
  logic                  trap_trig;
  logic                  clk_dead;
  logic                  trap_active;
  logic                  sysclk_active;
  logic                  wdt_active;
  logic                  int_active;
  mrg_cause_s            src_now;
  logic                  next_core_reset;
  logic                  reset_entry;
  logic                  reset_exit;
  logic                  next_pin_oe_n;
  mrg_cause_s            next_reset_cause;
  mrg_core_init_s        next_core_init;

  // Window compares kept apart so each range can be moved on its own
  assign in_sfr = (fetch_addr >= `MRG_SFR_LO) && (fetch_addr <= `MRG_SFR_HI);
  assign in_ram = (fetch_addr >= `MRG_RAM_LO) && (fetch_addr <= `MRG_RAM_HI);
  assign in_dbr = (fetch_addr >= `MRG_DBR_LO) && (fetch_addr <= `MRG_DBR_HI);

  // Address trap window decode
  always_comb begin
    trap_hit = 1'b0;
    if (!fetch_valid) begin
      trap_hit = 1'b0;
    end else if (in_sfr) begin
      trap_hit = 1'b1;
    end else if (in_ram) begin
      trap_hit = 1'b1;
    end else if (in_dbr) begin
      trap_hit = 1'b1;
    end
  end

  // A dead clock select would stop the oscillator for good
  assign clk_dead = (sys_ctrl_two[`MRG_CLK_SEL_HI:`MRG_CLK_SEL_LO] == `MRG_CLK_DEAD);

  // Trap is masked while already in reset so the stalled core cannot retrigger
  assign trap_trig = trap_hit && !core_reset;

  mrg_pulse u_trap (
    .clk    (clk),
    .rst    (rst),
    .trig   (trap_trig),
    .active (trap_active)
  );

  // Clock-stop request retriggers while the select bits stay dead
  mrg_pulse u_sysclk (
    .clk    (clk),
    .rst    (rst),
    .trig   (clk_dead),
    .active (sysclk_active)
  );

  // Watchdog request is stretched as well, so the pin is driven for it too
  mrg_pulse u_wdt (
    .clk    (clk),
    .rst    (rst),
    .trig   (wdt_reset_req),
    .active (wdt_active)
  );

  // Any internal source drives the pin and holds the core
  assign int_active = trap_active || sysclk_active || wdt_active;

  // Pin low filter; shorter glitches never reach the core
  // Own drive clears the count, else its release would look external
  assign ext_clear = reset_pin_in_n || !reset_pin_oe_n;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_cnt <= '0;
    end else if (ext_clear) begin
      ext_cnt <= '0;
    end else if (ext_cnt != `MRG_CNT_W'(`MRG_EXT_MIN_CYC)) begin
      ext_cnt <= ext_cnt + `MRG_CNT_W'(1);
    end
  end

  // Saturated count is the pin request; it stands while the pin stays low
  assign ext_reset = (ext_cnt == `MRG_CNT_W'(`MRG_EXT_MIN_CYC)) && reset_pin_oe_n;

  // Entry and exit edges of the core reset, seen one cycle ahead
  assign next_core_reset = ext_reset || int_active;
  assign reset_entry     = next_core_reset && !core_reset;
  assign reset_exit      = core_reset && !next_core_reset;

  // Registered so the core sees one clean edge however sources overlap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= next_core_reset;
    end
  end

  // Only low is ever driven; the board pull-up gives the high level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_pin_out_n <= 1'b0;
    end else begin
      reset_pin_out_n <= 1'b0;
    end
  end

  assign next_pin_oe_n = !int_active;

  // Power-up reset also drives the pin until the first edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_pin_oe_n <= 1'b0;
    end else begin
      reset_pin_oe_n <= next_pin_oe_n;
    end
  end

  // Live view of every source, in the layout of the latched cause
  always_comb begin
    src_now.ext    = ext_reset;
    src_now.trap   = trap_active;
    src_now.wdt    = wdt_active;
    src_now.sysclk = sysclk_active;
  end

  // Causes latched once at entry so a later source cannot mask the first
  always_comb begin
    next_reset_cause = reset_cause;
    if (reset_entry) begin
      next_reset_cause = src_now;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_cause <= '0;
    end else begin
      reset_cause <= next_reset_cause;
    end
  end

  // Core init values held throughout reset; only rst shows zeros
  always_comb begin
    next_core_init.bank_selector          = '0;
    next_core_init.jump_status_flag       = 1'b1;
    next_core_init.irq_master_enable      = 1'b0;
    next_core_init.irq_individual_enables = '0;
    next_core_init.irq_latches            = '0;
    next_core_init.prescaler              = '0;
    next_core_init.watchdog_enable        = 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_init <= '0;
    end else begin
      core_init <= next_core_init;
    end
  end

  // Vector location is fixed; the core loads its start address from it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_addr <= `MRG_VEC_ADDR;
    end else begin
      vector_addr <= `MRG_VEC_ADDR;
    end
  end

  // Strobe marks the first cycle in which the core runs again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_fetch <= 1'b0;
    end else begin
      vector_fetch <= reset_exit;
    end
  end
endmodule

// >>> dv/mrg_line_model.sv
// Board side of the reset line: an outside driver plus a pull-up.
// Assumes the generator only ever pulls the line low.
`timescale 1ns/1ps
module mrg_line_model (
  input  wire logic ext_low,
  input  wire logic reset_pin_out_n,
  input  wire logic reset_pin_oe_n,
  output logic      reset_pin_in_n
);
  // Wired-AND over the pull-up, so a released line reads high
  assign reset_pin_in_n = ~(ext_low | (~reset_pin_oe_n & ~reset_pin_out_n));
endmodule

// >>> dv/mrg_reset_gen_properties.sv
// Port checks for the reset generator.
// Assumes one clock; bound to every instance below.
`timescale 1ns/1ps
module mrg_reset_gen_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reset_pin_in_n,
  input wire logic        reset_pin_oe_n,
  input wire logic        fetch_valid,
  input wire logic [19:0] fetch_addr,
  input wire logic        wdt_reset_req,
  input wire logic [7:0]  sys_ctrl_two,
  input wire logic        core_reset,
  input wire logic        vector_fetch
);
  logic [4:0] pin_lo;
  logic [4:0] oe_lo;
  wire trap_hit = fetch_valid && !core_reset && (fetch_addr <= 20'h0083f || fetch_addr[19:7] == 13'h001f);
  // Own drive on the line must not count as an outside request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pin_lo <= '0;
    else pin_lo <= (reset_pin_in_n | ~reset_pin_oe_n) ? '0 : pin_lo + {4'h0, ~&pin_lo};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) oe_lo <= '0;
    else oe_lo <= reset_pin_oe_n ? '0 : oe_lo + {4'h0, ~&oe_lo};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_int_on;
    ##2 (!reset_pin_oe_n && core_reset);
  endsequence
  AST_EXT: assert property (pin_lo == 5'hc |-> ##[1:2] core_reset)
    else $error("pin reset missed");
  AST_TRAP: assert property (trap_hit |-> s_int_on)
    else $error("trap reset missed");
  AST_CLK: assert property (sys_ctrl_two[7:5] == 3'h0 && !core_reset |-> s_int_on)
    else $error("clock reset missed");
  AST_WDT: assert property (wdt_reset_req |-> ##[1:2] core_reset)
    else $error("watchdog reset missed");
  AST_MIN: assert property ($fell(reset_pin_oe_n) |-> !reset_pin_oe_n [*8])
    else $error("drive too short");
  AST_MAX: assert property (oe_lo <= 5'h18)
    else $error("drive too long");
  AST_VEC: assert property ($fell(core_reset) |-> vector_fetch)
    else $error("no vector fetch");
  AST_ONE: assert property (vector_fetch |=> !vector_fetch)
    else $error("vector fetch too long");
  AST_REL: assert property ($rose(reset_pin_oe_n) |-> $fell(core_reset))
    else $error("reset outlives drive");
endmodule
bind mrg_reset_gen mrg_reset_gen_properties u_props (
  .clk            (clk),
  .rst            (rst),
  .reset_pin_in_n (reset_pin_in_n),
  .reset_pin_oe_n (reset_pin_oe_n),
  .fetch_valid    (fetch_valid),
  .fetch_addr     (fetch_addr),
  .wdt_reset_req  (wdt_reset_req),
  .sys_ctrl_two   (sys_ctrl_two),
  .core_reset     (core_reset),
  .vector_fetch   (vector_fetch)
);

// >>> dv/mrg_reset_gen_test.sv
// Bench for the reset generator and its reset line.
// Assumes the line model stands in for the board.
`timescale 1ns/1ps
module mrg_reset_gen_test;
  import mrg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ext_low = 1'b0, fetch_valid = 1'b0, wdt_reset_req = 1'b0;
  logic [7:0] sys_ctrl_two = 8'he0;
  logic reset_pin_in_n, reset_pin_out_n, reset_pin_oe_n, core_reset, vector_fetch;
  mrg_addr_t fetch_addr = 20'h00000, vector_addr;
  mrg_core_init_s core_init;
  mrg_cause_s reset_cause;
  mrg_addr_t hits [5] = '{20'h00000, 20'h0083f, 20'h00fff, 20'h00840, 20'h00f7f};
  int miscompares = 0, total_checks = 0, cycles = 0;
  always #2.5 clk = ~clk;
  mrg_reset_gen u_dut (
    .clk             (clk),
    .rst             (rst),
    .reset_pin_in_n  (reset_pin_in_n),
    .reset_pin_out_n (reset_pin_out_n),
    .reset_pin_oe_n  (reset_pin_oe_n),
    .fetch_valid     (fetch_valid),
    .fetch_addr      (fetch_addr),
    .wdt_reset_req   (wdt_reset_req),
    .sys_ctrl_two    (sys_ctrl_two),
    .core_reset      (core_reset),
    .core_init       (core_init),
    .vector_addr     (vector_addr),
    .vector_fetch    (vector_fetch),
    .reset_cause     (reset_cause)
  );
  mrg_line_model u_line (
    .ext_low         (ext_low),
    .reset_pin_out_n (reset_pin_out_n),
    .reset_pin_oe_n  (reset_pin_oe_n),
    .reset_pin_in_n  (reset_pin_in_n)
  );
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic leave(logic [3:0] cause);
    int n;
    n = 0;
    while (core_reset !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
    check("cause", reset_cause, cause);
    check("vector", {vector_fetch, vector_addr}, {1'b1, 20'hffffc});
    tick(1);
    check("vector end", {vector_fetch, core_reset}, 2'b00);
  endtask
  // k selects trap, watchdog or clock-stop as one-hot
  task automatic internal(logic [2:0] k, mrg_addr_t a, logic hit);
    int n;
    n = 0;
    @(posedge clk);
    {fetch_valid, wdt_reset_req} <= k[2:1];
    sys_ctrl_two <= k[0] ? 8'h1f : 8'he0;
    fetch_addr <= a;
    @(posedge clk);
    {fetch_valid, wdt_reset_req} <= 2'b00;
    sys_ctrl_two <= 8'he0;
    tick(2);
    check("drive", {reset_pin_oe_n, reset_pin_out_n, reset_pin_in_n, core_reset}, {!hit, 1'b0, !hit, hit});
    if (!hit) return;
    while (reset_pin_oe_n === 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
    check("length", n >= 8 && n <= 24, 1'b1);
    leave({1'b0, k});
  endtask
  task automatic ext(int n);
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (n) @(posedge clk);
    #1;
    check("pin entry", core_reset, n > 11);
    @(posedge clk);
    ext_low <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    check("powerup", reset_pin_oe_n, 1'b0);
    rst <= 1'b0;
    tick(4);
    check("init", core_init, {4'h2, 48'h0, 1'h1});
    ext(10);
    tick(3);
    check("short pin", core_reset, 1'b0);
    ext(14);
    leave(4'h8);
    for (int i = 0; i < 5; i++) internal(3'h4, hits[i], i < 3);
    internal(3'h2, 20'h00000, 1'b1);
    internal(3'h1, 20'h00000, 1'b1);
    conclude();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      conclude();
    end
  end
endmodule
